// file: core/cmd_device.sv
// Purpose: Device end: decodes group, threshold and calibration commands
// Assumes: Link and user side on clk_sys; ce freezes all state
// Notes:   Answers two edges after a command is taken
//
// Function
// - Six-bit status unused in commands, filled in answers
// - Direction 0 read, 1 write, per-command allowed
// - Element codes 0 to 99 select channels
// - Element codes 100 to 149 select groups
// - Group read answers reserved byte, sixteen flags
// - Threshold command reads or writes overload, limit
// - Overload threshold raw 24-bit, scaled and offset
// - Current limit raw 16-bit, scaled by half
// - Calibration write-only, one channel, type, data
// - Calibration types: offset, current, voltage, factory
// - Offset calibration with channel off runs
// - Offset calibration with channel on errors 0x3F
// - Current slope data is current-times-100 plus offset
// - Voltage slope data is voltage-times-20 plus offset
// - Factory setting restores calibration, ignores data
`timescale 1ns/1ns
`include "pdu_cmd_defs.svh"
module cmd_device #(
  parameter int NCH  = 16,
  parameter int NGRP = 50
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       ce,
  pdu_link_if.dev         link,
  input  wire logic [15:0] ch_on,
  input  wire logic       grp_wr,
  input  wire logic [5:0] grp_sel,
  input  wire logic [15:0] grp_mask,
  output logic            thr_upd,
  output logic [7:0]      thr_elem,
  output logic [23:0]     thr_ovl,
  output logic [15:0]     thr_lim,
  output logic            cal_go,
  output logic [3:0]      cal_chan,
  output logic [1:0]      cal_kind,
  output logic [23:0]     cal_val
);
  localparam int NENT = NCH + NGRP;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] grp_mem_q [NGRP];
  logic [23:0] ovl_mem_q [NENT];
  logic [15:0] lim_mem_q [NENT];

  pdu_cmd_pkg::dev_state_t state_q;
  logic [7:0]  code_q;
  logic [1:0]  dir_q;
  logic [7:0]  elem_q;
  logic [39:0] data_q;

  logic        is_chan;
  logic        chan_fitted;
  logic        is_grp;
  logic [7:0]  index;

  elem_decode #(.NCH(NCH)) u_dec (
    .elem        (elem_q),
    .is_chan     (is_chan),
    .chan_fitted (chan_fitted),
    .is_grp      (is_grp),
    .index       (index)
  );

  // ----------------------------------------
  // Decode of the held command
  // ----------------------------------------
  logic        grp_ok;
  logic [6:0]  ent;
  logic        ent_ok;
  logic        thr_wr;
  logic        cal_ok;
  logic [7:0]  cal_type;
  logic [23:0] cal_data;
  logic [5:0]  status_d;
  logic [7:0]  rcode_d;
  logic [39:0] rdata_d;

  always_comb begin
    grp_ok   = is_grp && (index < 8'(NGRP));
    ent      = is_grp ? 7'(index + 8'(NCH)) : 7'(index);
    ent_ok   = chan_fitted || grp_ok;
    cal_type = data_q[`PL_CALIBRATION_TYPE_LSB +: 8];
    cal_data = data_q[`PL_CALDATA_LSB +: 24];
    thr_wr   = 1'b0;
    cal_ok   = 1'b0;
    status_d = `ST_GENERAL_ERR;
    rcode_d  = 8'(code_q + 8'h01);
    rdata_d  = 40'h00_0000_0000;
    case (code_q)
      `OP_GRP_RD_CMD: begin
        rcode_d = `OP_GRP_RD_RSP;
        if (dir_q == pdu_cmd_pkg::DIR_READ && grp_ok) begin
          status_d = `ST_OK;
          for (int i = 0; i < 16; i++) begin
            rdata_d[2*i +: 2] = {1'b0, grp_mem_q[index[5:0]][i]};
          end
          rdata_d[`PL_RSVD_LSB +: 8] = 8'h00;
        end
      end
      `OP_THR_CMD: begin
        rcode_d = `OP_THR_RSP;
        if (ent_ok && dir_q == pdu_cmd_pkg::DIR_WRITE) begin
          status_d = `ST_OK;
          thr_wr   = 1'b1;
          rdata_d  = data_q;
        end else if (ent_ok && dir_q == pdu_cmd_pkg::DIR_READ) begin
          status_d = `ST_OK;
          rdata_d  = {ovl_mem_q[ent], lim_mem_q[ent]};
        end
      end
      `OP_CAL_CMD: begin
        rcode_d = `OP_CAL_RSP;
        if (dir_q == pdu_cmd_pkg::DIR_WRITE && chan_fitted) begin
          case (cal_type)
            pdu_cmd_pkg::CAL_OFFSET: begin
              cal_ok = !ch_on[index[3:0]];
            end
            pdu_cmd_pkg::CAL_CUR: begin
              cal_ok = 1'b1;
            end
            pdu_cmd_pkg::CAL_VOLT: begin
              cal_ok = 1'b1;
            end
            pdu_cmd_pkg::CAL_FACTORY: begin
              cal_ok = 1'b1;
            end
            default: begin
              cal_ok = 1'b0;
            end
          endcase
          if (cal_ok) begin
            status_d = `ST_OK;
          end
          rdata_d = data_q;
        end
      end
      default: begin
        status_d = `ST_GENERAL_ERR;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  // A command arriving while one executes is dropped; the host waits
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= pdu_cmd_pkg::ST_IDLE;
    end else if (ce) begin
      case (state_q)
        pdu_cmd_pkg::ST_IDLE: begin
          if (link.cmd_valid) begin
            state_q <= pdu_cmd_pkg::ST_EXEC;
          end
        end
        pdu_cmd_pkg::ST_EXEC: begin
          state_q <= pdu_cmd_pkg::ST_IDLE;
        end
        default: begin
          state_q <= pdu_cmd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Command status field is ignored on purpose
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      code_q <= 8'h00;
      dir_q  <= 2'h0;
      elem_q <= 8'h00;
      data_q <= 40'h00_0000_0000;
    end else if (ce && state_q == pdu_cmd_pkg::ST_IDLE && link.cmd_valid) begin
      code_q <= link.cmd_code;
      dir_q  <= link.cmd_dir;
      elem_q <= link.cmd_elem;
      data_q <= link.cmd_data;
    end
  end

  // ----------------------------------------
  // Memories
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int g = 0; g < NGRP; g++) begin
        grp_mem_q[g] <= 16'h0000;
      end
    end else if (ce && grp_wr && grp_sel < 6'(NGRP)) begin
      grp_mem_q[grp_sel] <= grp_mask;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int e = 0; e < NENT; e++) begin
        ovl_mem_q[e] <= `OVL_RST;
        lim_mem_q[e] <= `LIM_RST;
      end
    end else if (ce && state_q == pdu_cmd_pkg::ST_EXEC && thr_wr) begin
      ovl_mem_q[ent] <= data_q[`PL_OVL_LSB +: 24];
      lim_mem_q[ent] <= data_q[`PL_LIM_LSB +: 16];
    end
  end

  // ----------------------------------------
  // Answer and user-side strobes
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link.rsp_valid  <= 1'b0;
      link.rsp_code   <= 8'h00;
      link.rsp_status <= 6'h00;
      link.rsp_dir    <= 2'h0;
      link.rsp_elem   <= 8'h00;
      link.rsp_data   <= 40'h00_0000_0000;
    end else if (ce) begin
      link.rsp_valid <= (state_q == pdu_cmd_pkg::ST_EXEC);
      if (state_q == pdu_cmd_pkg::ST_EXEC) begin
        link.rsp_code   <= rcode_d;
        link.rsp_status <= status_d;
        link.rsp_dir    <= dir_q;
        link.rsp_elem   <= elem_q;
        link.rsp_data   <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      thr_upd  <= 1'b0;
      thr_elem <= 8'h00;
      thr_ovl  <= `OVL_RST;
      thr_lim  <= `LIM_RST;
      cal_go   <= 1'b0;
      cal_chan <= 4'h0;
      cal_kind <= 2'h0;
      cal_val  <= 24'h00_0000;
    end else if (ce) begin
      thr_upd <= (state_q == pdu_cmd_pkg::ST_EXEC) && thr_wr;
      cal_go  <= (state_q == pdu_cmd_pkg::ST_EXEC) && cal_ok;
      if (state_q == pdu_cmd_pkg::ST_EXEC && thr_wr) begin
        thr_elem <= elem_q;
        thr_ovl  <= data_q[`PL_OVL_LSB +: 24];
        thr_lim  <= data_q[`PL_LIM_LSB +: 16];
      end
      if (state_q == pdu_cmd_pkg::ST_EXEC && cal_ok) begin
        cal_chan <= index[3:0];
        cal_kind <= cal_type[1:0];
        // Offset and factory requests carry no data downstream
        cal_val  <= (cal_type[0] ^ cal_type[1]) ? cal_data : 24'h00_0000;
      end
    end
  end
endmodule

// file: core/cmd_host.sv
// Purpose: Host end: sends commands ordered over Wishbone, keeps answers
// Assumes: Classic Wishbone slave on clk_sys; ce freezes all state
// Notes:   One command in flight; a go while busy is ignored
`timescale 1ns/1ns
`include "pdu_cmd_defs.svh"
module cmd_host (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  pdu_link_if.host         link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq
);
  logic [23:0] ctrl_q;
  logic [39:0] arg_q;
  logic        busy_q;
  logic [7:0]  rcode_q;
  logic [5:0]  rstat_q;
  logic [39:0] rdata_q;
  logic [1:0]  int_stat_q;
  logic [1:0]  int_mask_q;
  logic        wr;
  logic        go;
  logic [31:0] rd_d;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Ack follows the strobe by one edge; writes land on the ack edge
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign go = wr && wb_adr_i == `REG_CTRL && wb_sel_i[3] && wb_dat_i[`CTRL_GO_BIT] && !busy_q;

  always_comb begin
    case (wb_adr_i)
      `REG_CTRL:     rd_d = {8'h00, ctrl_q};
      `REG_ARG_LO:   rd_d = arg_q[31:0];
      `REG_ARG_HI:   rd_d = {24'h00_0000, arg_q[39:32]};
      `REG_RSP_STAT: rd_d = {17'h0_0000, busy_q, rstat_q, rcode_q};
      `REG_RSP_LO:   rd_d = rdata_q[31:0];
      `REG_RSP_HI:   rd_d = {24'h00_0000, rdata_q[39:32]};
      `REG_INT_STAT: rd_d = {30'h0000_0000, int_stat_q};
      `REG_INT_MASK: rd_d = {30'h0000_0000, int_mask_q};
      default:       rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q     <= 24'h00_0000;
      arg_q      <= 40'h00_0000_0000;
      int_mask_q <= 2'h0;
    end else if (ce && wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          if (wb_adr_i == `REG_ARG_LO) arg_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
          if (wb_adr_i == `REG_CTRL && b < 3) ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
      if (wb_adr_i == `REG_ARG_HI && wb_sel_i[0]) arg_q[39:32] <= wb_dat_i[7:0];
      if (wb_adr_i == `REG_INT_MASK && wb_sel_i[0]) int_mask_q <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------
  // Link side
  // ----------------------------------------
  // CTRL: [7:0] command code, [9:8] direction, [23:16] element
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link.cmd_valid  <= 1'b0;
      link.cmd_code   <= 8'h00;
      link.cmd_status <= 6'h00;
      link.cmd_dir    <= 2'h0;
      link.cmd_elem   <= 8'h00;
      link.cmd_data   <= 40'h00_0000_0000;
      busy_q          <= 1'b0;
    end else if (ce) begin
      link.cmd_valid <= go;
      if (go) begin
        link.cmd_code   <= wb_dat_i[7:0];
        link.cmd_status <= 6'h00;
        link.cmd_dir    <= wb_dat_i[9:8];
        link.cmd_elem   <= wb_dat_i[23:16];
        link.cmd_data   <= arg_q;
        busy_q          <= 1'b1;
      end else if (link.rsp_valid) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rcode_q <= 8'h00;
      rstat_q <= 6'h00;
      rdata_q <= 40'h00_0000_0000;
    end else if (ce && link.rsp_valid) begin
      rcode_q <= link.rsp_code;
      rstat_q <= link.rsp_status;
      rdata_q <= link.rsp_data;
    end
  end

  // ----------------------------------------
  // Interrupts: bit 0 answer came, bit 1 answer carried error
  // ----------------------------------------
  logic [1:0] ev;
  logic [1:0] clr;
  assign ev  = {link.rsp_valid && link.rsp_status != `ST_OK, link.rsp_valid};
  assign clr = (wr && wb_adr_i == `REG_INT_STAT && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_stat_q <= 2'h0;
      irq        <= 1'b0;
    end else if (ce) begin
      // Set wins over a clear in the same cycle
      int_stat_q <= (int_stat_q & ~clr) | ev;
      irq        <= |(((int_stat_q & ~clr) | ev) & int_mask_q);
    end
  end
endmodule

// file: core/elem_decode.sv
// Purpose: Classify an element selector as channel or group
// Assumes: Combinational, same clock as its user
// Notes:   Channels beyond the fitted count are flagged absent
`timescale 1ns/1ns
`include "pdu_cmd_defs.svh"
module elem_decode #(
  parameter int NCH = 16
) (
  input  wire logic [7:0] elem,
  output logic            is_chan,
  output logic            chan_fitted,
  output logic            is_grp,
  output logic [7:0]      index
);
  always_comb begin
    is_chan     = (elem <= `ELEM_CHAN_MAX);
    chan_fitted = is_chan && (elem < 8'(NCH));
    is_grp      = (elem >= `ELEM_GRP_BASE) && (elem <= `ELEM_GRP_MAX);
    index       = is_grp ? 8'(elem - `ELEM_GRP_BASE) : elem;
  end
endmodule

// file: core/pdu_cmd_defs.svh
// Purpose: Shared constants of the power unit command link
// Assumes: Included by bare name
// Notes:   Raw field codes plus reference scale factors; scaling is left to software
`ifndef PDU_CMD_DEFS_SVH
`define PDU_CMD_DEFS_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define OP_GRP_RD_CMD    8'h35
`define OP_GRP_RD_RSP    8'h36
`define OP_THR_CMD       8'h61
`define OP_THR_RSP       8'h62
`define OP_CAL_CMD       8'h67
`define OP_CAL_RSP       8'h68
// ----------------------------------------
// Status and element codes
// ----------------------------------------
`define ST_OK            6'h00
`define ST_GENERAL_ERR   6'h3f
`define ELEM_CHAN_MAX    8'h63
`define ELEM_GRP_BASE    8'h64
`define ELEM_GRP_MAX     8'h95
// ----------------------------------------
// Payload fields
// ----------------------------------------
`define PL_OVL_LSB       16
`define PL_LIM_LSB       0
`define PL_CALIBRATION_TYPE_LSB   32
`define PL_CALDATA_LSB   0
`define PL_RSVD_LSB      32
// Scaling of raw fields, for reference by software and benches
`define OVL_SCALE_MILLI  10
`define OVL_OFFSET_AMP   80000
`define LIM_SCALE_MILLI  500
`define CUR_CAL_OFFSET   8000000
`define VOLT_CAL_OFFSET  32120
// ----------------------------------------
// Reset values
// ----------------------------------------
`define OVL_RST          24'h7a1200
`define LIM_RST          16'h0000
// ----------------------------------------
// Host register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL         8'h00
`define REG_ARG_LO       8'h04
`define REG_ARG_HI       8'h08
`define REG_RSP_STAT     8'h0c
`define REG_RSP_LO       8'h10
`define REG_RSP_HI       8'h14
`define REG_INT_STAT     8'h18
`define REG_INT_MASK     8'h1c
`define CTRL_GO_BIT      31
`endif

// file: core/pdu_cmd_pkg.sv
// Purpose: Types of the power unit command link
// Assumes: Nothing
// Notes:   Constants stay in the defines header
package pdu_cmd_pkg;
  typedef enum logic [1:0] {
    DIR_READ  = 2'h0,
    DIR_WRITE = 2'h1
  } dir_t;
  typedef enum logic [7:0] {
    CAL_OFFSET  = 8'h00,
    CAL_CUR     = 8'h01,
    CAL_VOLT    = 8'h02,
    CAL_FACTORY = 8'h03
  } cal_kind_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } dev_state_t;
endpackage

// file: core/pdu_link_if.sv
// Purpose: Message-level link between host controller and device
// Assumes: Both ends on clk_sys
// Notes:   One message per valid pulse; host waits for the answer
`timescale 1ns/1ns
interface pdu_link_if;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [5:0]  cmd_status;
  logic [1:0]  cmd_dir;
  logic [7:0]  cmd_elem;
  logic [39:0] cmd_data;
  logic        rsp_valid;
  logic [7:0]  rsp_code;
  logic [5:0]  rsp_status;
  logic [1:0]  rsp_dir;
  logic [7:0]  rsp_elem;
  logic [39:0] rsp_data;
  modport dev (
    input  cmd_valid, cmd_code, cmd_status, cmd_dir, cmd_elem, cmd_data,
    output rsp_valid, rsp_code, rsp_status, rsp_dir, rsp_elem, rsp_data
  );
  modport host (
    output cmd_valid, cmd_code, cmd_status, cmd_dir, cmd_elem, cmd_data,
    input  rsp_valid, rsp_code, rsp_status, rsp_dir, rsp_elem, rsp_data
  );
endinterface

// file: testbench/link_assertions.sv
// Purpose: Timing and status checks on the command link
// Assumes: One clock domain, ce held high by the bench
// Notes:   Device state such as ch_on is not visible here
`timescale 1ns/1ns
module link_assertions (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic [5:0]  cmd_status,
  input wire logic [1:0]  cmd_dir,
  input wire logic [7:0]  cmd_elem,
  input wire logic [39:0] cmd_data,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_code,
  input wire logic [5:0]  rsp_status,
  input wire logic [39:0] rsp_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Link assertions
  // ----------------------------------------
  answer_delay_a: assert property (cmd_valid |-> ##2 rsp_valid)
    else $error("answer not two cycles after command");
  answer_cause_a: assert property (rsp_valid |-> $past(cmd_valid, 2))
    else $error("answer without command");
  answer_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  cmd_status_a: assert property (cmd_valid |-> cmd_status == 6'h00)
    else $error("command status not zero");
  rsp_code_a: assert property (rsp_valid |-> rsp_code == $past(cmd_code, 2) + 8'h01)
    else $error("answer code mismatch");
  status_set_a: assert property (rsp_valid |-> rsp_status inside {6'h00, 6'h3f})
    else $error("unknown status code");
  grp_layout_a: assert property (rsp_valid && rsp_code == 8'h36 && rsp_status == 6'h00
    |-> (rsp_data & 40'hff_aaaa_aaaa) == 40'h0)
    else $error("group answer layout wrong");
  grp_check_a: assert property (rsp_valid && rsp_code == 8'h36 |->
    (rsp_status == 6'h3f) ==
    ($past(cmd_dir, 2) != 2'h0 || !($past(cmd_elem, 2) inside {[8'h64:8'h95]})))
    else $error("group read status wrong");
  thr_check_a: assert property (rsp_valid && rsp_code == 8'h62 |->
    (rsp_status == 6'h3f) ==
    ($past(cmd_dir, 2) > 2'h1 ||
     !($past(cmd_elem, 2) inside {[8'h00:8'h0f], [8'h64:8'h95]})))
    else $error("threshold status wrong");
  cal_refuse_a: assert property (rsp_valid && rsp_code == 8'h68 &&
    ($past(cmd_dir, 2) != 2'h1
    || $past(cmd_elem, 2) > 8'h0f || $past(cmd_data[39:32], 2) > 8'h03)
    |-> rsp_status == 6'h3f)
    else $error("bad calibration not refused");
  grp_ok_c: cover property (rsp_valid && rsp_code == 8'h36 && rsp_status == 6'h00);
  thr_err_c: cover property (rsp_valid && rsp_code == 8'h62 && rsp_status == 6'h3f);
  cal_ok_c: cover property (rsp_valid && rsp_code == 8'h68 && rsp_status == 6'h00);
endmodule

// file: testbench/tb_top.sv
// Purpose: Host and device joined over the link, driven over Wishbone
// Assumes: 50 MHz clk_sys, ce always high
// Notes:   Busy is polled, so no fixed answer latency is assumed
`timescale 1ns/1ns
module tb_top;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_dat_o;
  logic        wb_ack, irq, grp_wr = 1'b0, thr_upd, cal_go;
  logic [15:0] ch_on = 16'h0, grp_mask = 16'h0, thr_lim;
  logic [5:0]  grp_sel = 6'h00;
  logic [7:0]  thr_elem;
  logic [23:0] thr_ovl, cal_val;
  logic [3:0]  cal_chan;
  logic [1:0]  cal_kind;
  int          errors = 0, n_checks = 0, cal_cnt = 0, thr_cnt = 0;
  pdu_link_if link ();
  cmd_host i_cmd_host (.clk_sys(clk_sys), .srst(srst), .ce(ce), .link(link),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .irq(irq));
  cmd_device i_cmd_device (.clk_sys(clk_sys), .srst(srst), .ce(ce), .link(link),
    .ch_on(ch_on), .grp_wr(grp_wr), .grp_sel(grp_sel), .grp_mask(grp_mask),
    .thr_upd(thr_upd), .thr_elem(thr_elem), .thr_ovl(thr_ovl), .thr_lim(thr_lim),
    .cal_go(cal_go), .cal_chan(cal_chan), .cal_kind(cal_kind), .cal_val(cal_val));
  link_assertions i_link_assertions (.clk_sys(clk_sys), .srst(srst),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_status(link.cmd_status),
    .cmd_dir(link.cmd_dir), .cmd_elem(link.cmd_elem), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_code(link.rsp_code), .rsp_status(link.rsp_status),
    .rsp_data(link.rsp_data));
  always #10 clk_sys = ~clk_sys;
  // Strobes are counted so a doubled or missing pulse is seen
  always @(posedge clk_sys) begin
    if (cal_go === 1'b1) cal_cnt++;
    if (thr_upd === 1'b1) thr_cnt++;
  end
  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    @(posedge clk_sys);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d; wb_sel <= 4'hf;
    @(posedge clk_sys);
    // No latency assumed; only the watchdog ends a lost ack
    while (wb_ack !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
  endtask
  task automatic send(input logic [7:0] code, input logic [1:0] dir, input logic [7:0] elem,
                      input logic [39:0] pl, output logic [5:0] st, output logic [39:0] rd);
    logic [31:0] q;
    wb_io(1'b1, 8'h04, pl[31:0], q);
    wb_io(1'b1, 8'h08, {24'h0, pl[39:32]}, q);
    wb_io(1'b1, 8'h00, {1'b1, 7'h0, elem, 6'h0, dir, code}, q);
    q = 32'h4000;
    while (q[14] !== 1'b0) begin
      wb_io(1'b0, 8'h0c, 32'h0, q);
    end
    st = q[13:8];
    chk("answer code", q[7:0], code + 8'h01);
    wb_io(1'b0, 8'h10, 32'h0, q);
    rd[31:0] = q;
    wb_io(1'b0, 8'h14, 32'h0, q);
    rd[39:32] = q[7:0];
  endtask
  task automatic t_reset();
    logic [31:0] q;
    chk("overload reset", thr_ovl, 24'h7a1200);
    chk("irq reset", irq, 1'b0);
    wb_io(1'b1, 8'hfc, 32'hffff_ffff, q);
    wb_io(1'b0, 8'hfc, 32'h0, q);
    chk("unmapped read", q, 32'h0);
    wb_io(1'b0, 8'h18, 32'h0, q);
    chk("int status reset", q, 32'h0);
    $display("Test reset done");
  endtask
  task automatic t_group();
    logic [5:0] st;
    logic [39:0] rd, ex;
    @(posedge clk_sys);
    grp_wr <= 1'b1; grp_sel <= 6'h31; grp_mask <= 16'h8005;
    @(posedge clk_sys);
    grp_wr <= 1'b0;
    ex = 40'h0;
    for (int i = 0; i < 16; i++) ex[2*i] = grp_mask[i];
    send(8'h35, 2'h0, 8'h95, 40'h0, st, rd);
    chk("group status", st, 6'h00);
    chk("group flags", rd, ex);
    send(8'h35, 2'h0, 8'h63, 40'h0, st, rd);
    chk("group on channel", st, 6'h3f);
    send(8'h35, 2'h1, 8'h95, 40'h0, st, rd);
    chk("group write", st, 6'h3f);
    $display("Test group done");
  endtask
  task automatic t_thr();
    logic [5:0] st;
    logic [39:0] rd;
    send(8'h61, 2'h1, 8'h0f, 40'h12_3456_0abc, st, rd);
    chk("thr status", st, 6'h00);
    chk("thr elem", thr_elem, 8'h0f);
    chk("thr overload", thr_ovl, 24'h123456);
    chk("thr limit", thr_lim, 16'h0abc);
    send(8'h61, 2'h0, 8'h0f, 40'h0, st, rd);
    chk("thr readback", rd, 40'h12_3456_0abc);
    send(8'h61, 2'h1, 8'h64, 40'hff_ffff_ffff, st, rd);
    chk("thr group", st, 6'h00);
    send(8'h61, 2'h1, 8'h10, 40'h0, st, rd);
    chk("thr unfitted", st, 6'h3f);
    send(8'h61, 2'h1, 8'h96, 40'h0, st, rd);
    chk("thr out of range", st, 6'h3f);
    send(8'h61, 2'h2, 8'h00, 40'h0, st, rd);
    chk("thr bad dir", st, 6'h3f);
    chk("thr updates", thr_cnt, 2);
    send(8'h70, 2'h0, 8'h00, 40'h0, st, rd);
    chk("unknown code", st, 6'h3f);
    $display("Test threshold done");
  endtask
  task automatic t_cal();
    logic [5:0] st;
    logic [39:0] rd;
    logic [23:0] d;
    for (int k = 0; k < 4; k++) begin
      d = (k == 2) ? 24'h007e68 : 24'h7a1264;
      send(8'h67, 2'h1, 8'h02, {k[7:0], 8'h0, d}, st, rd);
      chk("cal status", st, 6'h00);
      chk("cal kind", cal_kind, k[1:0]);
      chk("cal chan", cal_chan, 4'h2);
      chk("cal value", cal_val, (k == 1 || k == 2) ? d : 24'h0);
    end
    chk("cal starts", cal_cnt, 4);
    ch_on <= 16'h0004;
    send(8'h67, 2'h1, 8'h02, 40'h0, st, rd);
    chk("cal channel on", st, 6'h3f);
    send(8'h67, 2'h1, 8'h02, 40'h04_0000_0000, st, rd);
    chk("cal bad type", st, 6'h3f);
    send(8'h67, 2'h1, 8'h10, 40'h03_0000_0000, st, rd);
    chk("cal bad chan", st, 6'h3f);
    send(8'h67, 2'h0, 8'h01, 40'h03_0000_0000, st, rd);
    chk("cal read", st, 6'h3f);
    chk("cal refused", cal_cnt, 4);
    $display("Test calibration done");
  endtask
  task automatic t_irq();
    logic [5:0] st;
    logic [39:0] rd;
    logic [31:0] q;
    wb_io(1'b1, 8'h18, 32'h3, q);
    send(8'h35, 2'h0, 8'h00, 40'h0, st, rd);
    wb_io(1'b0, 8'h18, 32'h0, q);
    chk("error event", q[1], 1'b1);
    chk("irq masked", irq, 1'b0);
    wb_io(1'b1, 8'h1c, 32'h2, q);
    repeat (2) @(posedge clk_sys);
    chk("irq raised", irq, 1'b1);
    wb_io(1'b1, 8'h18, 32'h2, q);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    $display("Test interrupt done");
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_group();
    t_thr();
    t_cal();
    t_irq();
    finish_test();
  end
endmodule
